/* include/driver_configuration_pkg.sv */
// Package: register map, field layout and decode tables of the driver configuration block
package driver_configuration_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] CFG_OFFSET = 7'h05;
  localparam logic [DATA_W-1:0] CFG_RESET = 32'h00000000;
  localparam logic [DATA_W-1:0] CFG_WRITE_MASK = 32'h00770FFF;
  // Field positions indexed by motor number
  localparam int IDLE_LSB [2] = '{16, 20};
  localparam int IDLE_W = 3;
  localparam int SRC_BIT [2] = '{5, 11};
  localparam int EN_BIT [2] = '{4, 10};
  localparam int IREF_LSB [2] = '{2, 8};
  localparam int FSR_LSB [2] = '{0, 6};
  localparam int CODE_W = 2;
  // Idle delay is 2^(IDLE_EXP_MAX - field) clock cycles
  localparam int IDLE_EXP_MAX = 20;
  // Reference current in percent, per scaling code
  localparam int PCT_W = 7;
  localparam logic [PCT_W-1:0] IREF_PCT [4] = '{7'h19, 7'h32, 7'h4B, 7'h64};
  // Full-scale coefficient in hundredths: 2.05, 4.08, 6.03, 8.00
  localparam int COEF_W = 10;
  localparam logic [COEF_W-1:0] FSR_COEF [4] = '{10'h0CD, 10'h198, 10'h25B, 10'h320};
endpackage

/* src/driver_configuration.sv */
// Driver configuration register with per-motor standstill timing and emergency driver off
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Motor 1 standstill after 2^(20 - idle field) cycles; field 0 gives 2^20.
// - Motor 0 standstill uses the same idle delay decoding with its own field.
// - Motor 1 halt enable set: driver off when selected switch pair both active.
// - Motor 1 source bit: 0 own pair only, 1 either motor's pair.
// - Motor 0 halt enable set: driver off when selected switch pair both active.
// - Motor 0 source bit: 0 own pair only, 1 either motor's pair.
// - Motor 1 reference current scale codes 0..3 give 25, 50, 75, 100 percent.
// - Motor 0 reference current scale in quarter steps, 25 to 100 percent.
// - Motor 1 sense range codes give coefficients 2.05, 4.08, 6.03, 8.00.
// - Motor 0 sense range codes give coefficients 2.05, 4.08, 6.03, 8.00.
// - Sense range code also sets that motor's overcurrent threshold.
module driver_configuration #(
  parameter int IDLE_EXP = driver_configuration_pkg::IDLE_EXP_MAX
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic regWrite,
  input wire logic [driver_configuration_pkg::ADDR_W-1:0] regAddr,
  input wire logic [driver_configuration_pkg::DATA_W-1:0] regWrData,
  output logic [driver_configuration_pkg::DATA_W-1:0] regRdData,
  input wire logic motor0Step,
  input wire logic motor1Step,
  input wire logic motor0LeftSwitch,
  input wire logic motor0RightSwitch,
  input wire logic motor1LeftSwitch,
  input wire logic motor1RightSwitch,
  output logic [1:0] standstill,
  output logic [1:0] driverHalt,
  output logic [driver_configuration_pkg::PCT_W-1:0] motor0RefPercent,
  output logic [driver_configuration_pkg::PCT_W-1:0] motor1RefPercent,
  output logic [driver_configuration_pkg::COEF_W-1:0] motor0SenseCoef,
  output logic [driver_configuration_pkg::COEF_W-1:0] motor1SenseCoef,
  output logic [driver_configuration_pkg::CODE_W-1:0] motor0OcThreshold,
  output logic [driver_configuration_pkg::CODE_W-1:0] motor1OcThreshold
);
  localparam int CNT_W = IDLE_EXP + 1;
  localparam int PCT_W = driver_configuration_pkg::PCT_W;

  // The shortest delay must still be at least one cycle and the counter must fit
  if (IDLE_EXP < 7 || IDLE_EXP > 30) begin : g_bad_exp
    $error("IDLE_EXP must lie between 7 and 30");
  end

  logic [driver_configuration_pkg::DATA_W-1:0] config_r;
  logic [CNT_W-1:0] idleCnt_r [2];
  logic [CNT_W-1:0] idleLimit [2];
  logic [1:0] step;
  logic [1:0] pairActive;
  logic [1:0] haltTrig;
  logic cfgHit;

  assign step = {motor1Step, motor0Step};
  assign pairActive = {motor1LeftSwitch & motor1RightSwitch, motor0LeftSwitch & motor0RightSwitch};
  assign cfgHit = (regAddr == driver_configuration_pkg::CFG_OFFSET);

  // ****************************************
  // Register access
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      config_r <= driver_configuration_pkg::CFG_RESET;
    end else if (regWrite && cfgHit) begin
      config_r <= regWrData & driver_configuration_pkg::CFG_WRITE_MASK;
    end
  end

  // Unmapped addresses read zero so the host never sees stale data
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      regRdData <= '0;
    end else begin
      regRdData <= cfgHit ? config_r : '0;
    end
  end

  // ****************************************
  // Standstill timing and emergency halt
  // ****************************************
  always_comb begin
    for (int m = 0; m < 2; m++) begin
      idleLimit[m] = CNT_W'(1) << (IDLE_EXP - int'(config_r[driver_configuration_pkg::IDLE_LSB[m] +: driver_configuration_pkg::IDLE_W]));
      // Source bit widens the trigger to the other motor's pair as well
      haltTrig[m] = pairActive[m] | (config_r[driver_configuration_pkg::SRC_BIT[m]] & pairActive[1-m]);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int m = 0; m < 2; m++) begin
        idleCnt_r[m] <= '0;
      end
      standstill <= '0;
    end else begin
      for (int m = 0; m < 2; m++) begin
        if (step[m]) begin
          idleCnt_r[m] <= '0;
        end else if (idleCnt_r[m] < idleLimit[m]) begin
          idleCnt_r[m] <= idleCnt_r[m] + CNT_W'(1);
        end
        // Counter saturates at the limit, so shortening the delay mid-count flags at once
        standstill[m] <= !step[m] && (idleCnt_r[m] >= idleLimit[m] - CNT_W'(1));
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      driverHalt <= '0;
    end else begin
      for (int m = 0; m < 2; m++) begin
        driverHalt[m] <= config_r[driver_configuration_pkg::EN_BIT[m]] & haltTrig[m];
      end
    end
  end

  // ****************************************
  // Current scaling and sense range decode
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      motor0RefPercent <= '0;
      motor1RefPercent <= '0;
      motor0SenseCoef <= '0;
      motor1SenseCoef <= '0;
      motor0OcThreshold <= '0;
      motor1OcThreshold <= '0;
    end else begin
      motor0RefPercent <= driver_configuration_pkg::IREF_PCT[config_r[driver_configuration_pkg::IREF_LSB[0] +: 2]];
      motor1RefPercent <= driver_configuration_pkg::IREF_PCT[config_r[driver_configuration_pkg::IREF_LSB[1] +: 2]];
      motor0SenseCoef <= driver_configuration_pkg::FSR_COEF[config_r[driver_configuration_pkg::FSR_LSB[0] +: 2]];
      motor1SenseCoef <= driver_configuration_pkg::FSR_COEF[config_r[driver_configuration_pkg::FSR_LSB[1] +: 2]];
      // Overcurrent comparators take the range code itself as their threshold select
      motor0OcThreshold <= config_r[driver_configuration_pkg::FSR_LSB[0] +: 2];
      motor1OcThreshold <= config_r[driver_configuration_pkg::FSR_LSB[1] +: 2];
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_unused_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (config_r & ~driver_configuration_pkg::CFG_WRITE_MASK) == '0)
    else $error("Unused configuration bits are not zero");

  a_write_readback: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rst_n && regWrite && cfgHit ##1 cfgHit |=> regRdData == ($past(regWrData, 2) & driver_configuration_pkg::CFG_WRITE_MASK))
    else $error("Written value does not read back masked");

  for (genvar g = 0; g < 2; g++) begin : g_chk
    a_step_restart: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rst_n && step[g] |=> !standstill[g] && idleCnt_r[g] == '0)
      else $error("Step did not restart the idle count");

    a_idle_delay: assert property (@(posedge clk_sys) disable iff (!rst_n)
      // A delay shortened mid-count may flag with the count already past the new limit
      $rose(standstill[g]) && $stable(idleLimit[g]) && $past(idleLimit[g], 2) == idleLimit[g]
      |-> idleCnt_r[g] == idleLimit[g])
      else $error("Standstill rose at the wrong count");

    a_halt_enable: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rst_n && !config_r[driver_configuration_pkg::EN_BIT[g]] |=> !driverHalt[g])
      else $error("Driver halted while halt is disabled");

    a_halt_own: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rst_n && config_r[driver_configuration_pkg::EN_BIT[g]] && pairActive[g] |=> driverHalt[g])
      else $error("Own switch pair did not halt the driver");

    a_halt_source: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rst_n && config_r[driver_configuration_pkg::EN_BIT[g]] && !pairActive[g] && pairActive[1-g]
      |=> driverHalt[g] == $past(config_r[driver_configuration_pkg::SRC_BIT[g]]))
      else $error("Other switch pair handled against the source bit");
  end

  // Sampled reset in the antecedent keeps the release edge, where outputs still hold reset values, out
  a_ref_scale: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rst_n |=> motor1RefPercent == PCT_W'(25 * (int'($past(config_r[driver_configuration_pkg::IREF_LSB[1] +: 2])) + 1))
    && motor0RefPercent == PCT_W'(25 * (int'($past(config_r[driver_configuration_pkg::IREF_LSB[0] +: 2])) + 1)))
    else $error("Reference percent does not match its code");

  // Coefficients written out in hundredths, so a wrong decode table is caught
  a_sense_coef1: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rst_n |=> motor1SenseCoef == (
      $past(config_r[driver_configuration_pkg::FSR_LSB[1] +: 2]) == 2'h0 ? 10'h0CD :
      $past(config_r[driver_configuration_pkg::FSR_LSB[1] +: 2]) == 2'h1 ? 10'h198 :
      $past(config_r[driver_configuration_pkg::FSR_LSB[1] +: 2]) == 2'h2 ? 10'h25B : 10'h320))
    else $error("Motor 1 sense coefficient does not match its range code");

  a_sense_coef0: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rst_n |=> motor0SenseCoef == (
      $past(config_r[driver_configuration_pkg::FSR_LSB[0] +: 2]) == 2'h0 ? 10'h0CD :
      $past(config_r[driver_configuration_pkg::FSR_LSB[0] +: 2]) == 2'h1 ? 10'h198 :
      $past(config_r[driver_configuration_pkg::FSR_LSB[0] +: 2]) == 2'h2 ? 10'h25B : 10'h320))
    else $error("Motor 0 sense coefficient does not match its range code");

  a_oc_threshold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rst_n |=> motor0OcThreshold == $past(config_r[driver_configuration_pkg::FSR_LSB[0] +: 2])
    && motor1OcThreshold == $past(config_r[driver_configuration_pkg::FSR_LSB[1] +: 2]))
    else $error("Overcurrent threshold does not follow the range code");
endmodule
`default_nettype wire

/* tb/motor_side_model.sv */
// Far-side model: step pulses and reference switch levels seen by the driver block
`timescale 1ns/1ps
`default_nettype none
module motor_side_model (
  input wire logic clk_sys,
  input wire logic [1:0] stepCmd,
  input wire logic [3:0] switchCmd,
  output var logic motor0Step = 1'b0,
  output var logic motor1Step = 1'b0,
  output var logic [3:0] switches = 4'h0
);
  // Registered like a pin input stage, so each change reaches the block one edge late
  always @(posedge clk_sys) begin
    motor0Step <= stepCmd[0];
    motor1Step <= stepCmd[1];
    switches <= switchCmd;
  end
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the driver configuration block
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {logic [31:0] cfg; logic [3:0] sw; logic [1:0] halt;} row_t;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic regWrite = 1'b0;
  logic [driver_configuration_pkg::ADDR_W-1:0] regAddr = 7'h05;
  logic [31:0] regWrData = 32'h0;
  logic [1:0] stepCmd = 2'h0;
  logic [3:0] switchCmd = 4'h0;
  logic [3:0] sw;
  logic m0Step, m1Step;
  logic [31:0] regRdData;
  logic [1:0] standstill, driverHalt, oc0, oc1;
  logic [6:0] pct0, pct1;
  logic [9:0] coef0, coef1;
  int fails = 0;
  int checks_done = 0;
  int n;
  localparam logic [6:0] PCT [4] = '{7'h19, 7'h32, 7'h4B, 7'h64};
  localparam logic [9:0] COEF [4] = '{10'h0CD, 10'h198, 10'h25B, 10'h320};
  // Switch order: m0 left, m0 right, m1 left, m1 right from bit 0 up
  row_t rows [5] = '{'{32'hFFFFF41B, 4'h3, 2'h1}, '{32'h00000E6E, 4'h3, 2'h2},
    '{32'h00000835, 4'hC, 2'h1}, '{32'h000007D0, 4'hC, 2'h2}, '{32'h00000DB0, 4'h5, 2'h0}};
  always #4 clk_sys = ~clk_sys;
  motor_side_model farSide (.clk_sys(clk_sys), .stepCmd(stepCmd), .switchCmd(switchCmd),
    .motor0Step(m0Step), .motor1Step(m1Step), .switches(sw));
  // Short exponent keeps idle delays at 2 to 256 cycles
  driver_configuration #(.IDLE_EXP(8)) DUT (.clk_sys(clk_sys), .rst_n(rst_n), .regWrite(regWrite),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .motor0Step(m0Step),
    .motor1Step(m1Step), .motor0LeftSwitch(sw[0]), .motor0RightSwitch(sw[1]),
    .motor1LeftSwitch(sw[2]), .motor1RightSwitch(sw[3]), .standstill(standstill),
    .driverHalt(driverHalt), .motor0RefPercent(pct0), .motor1RefPercent(pct1),
    .motor0SenseCoef(coef0), .motor1SenseCoef(coef1), .motor0OcThreshold(oc0),
    .motor1OcThreshold(oc1));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    if (fails == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    regAddr <= 7'h05;
  endtask
  task automatic wait_cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  // Second step lands mid-count on the 32 and 256 cycle delays, so a counter that misses the restart rises early
  task automatic idle_run(input int m, input int expL);
    logic [1:0] pulse;
    pulse = (m == 0) ? 2'h1 : 2'h2;
    @(posedge clk_sys);
    stepCmd <= pulse;
    @(posedge clk_sys);
    stepCmd <= 2'h0;
    repeat (4) @(posedge clk_sys);
    stepCmd <= pulse;
    for (n = 1; n <= 300; n++) begin
      @(posedge clk_sys);
      if (n == 1) stepCmd <= 2'h0;
      #1;
      if (n >= 3 && standstill[m] === 1'b1) break;
    end
    chk(32'(n), 32'(expL + 2));
    if (n > 300) end_sim();
  endtask
  // ******************************
  // Table cases, then hand cases
  // ******************************
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    wait_cyc(2);
    chk(regRdData, 32'h0);
    chk(32'({pct0, pct1}), 32'({7'h19, 7'h19}));
    chk(32'({coef0, coef1}), 32'({10'h0CD, 10'h0CD}));
    chk(32'({standstill, driverHalt, oc0, oc1}), 32'h0);
    foreach (rows[i]) begin
      wr(7'h05, rows[i].cfg);
      switchCmd <= rows[i].sw;
      wait_cyc(3);
      chk(regRdData, rows[i].cfg & 32'h00770FFF);
      chk(32'(driverHalt), 32'(rows[i].halt));
      chk(32'({pct0, pct1}), 32'({PCT[rows[i].cfg[3:2]], PCT[rows[i].cfg[9:8]]}));
      chk(32'({coef0, coef1}), 32'({COEF[rows[i].cfg[1:0]], COEF[rows[i].cfg[7:6]]}));
      chk(32'({oc0, oc1}), 32'({rows[i].cfg[1:0], rows[i].cfg[7:6]}));
    end
    wr(7'h06, 32'hFFFFFFFF);
    @(posedge clk_sys);
    regAddr <= 7'h06;
    wait_cyc(2);
    chk(regRdData, 32'h0);
    @(posedge clk_sys);
    regAddr <= 7'h05;
    wait_cyc(2);
    chk(regRdData, 32'h00000DB0);
    wr(7'h05, 32'h00700000);
    idle_run(1, 2);
    idle_run(0, 256);
    wr(7'h05, 32'h00030000);
    idle_run(0, 32);
    idle_run(1, 256);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    wait_cyc(2);
    chk(regRdData, 32'h0);
    chk(32'({standstill, driverHalt, oc0, oc1}), 32'h0);
    chk(32'({pct0, pct1}), 32'({7'h19, 7'h19}));
    end_sim();
  end
endmodule
`default_nettype wire
